// file: core/spc_serial_port.sv
`timescale 1ns/100ps
module spc_serial_port import spc_pkg::*; (
    input wire logic sys_clk, // 10 MHz system clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [2:0] addr, // Register offset
    input wire logic [7:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd_en
    output logic irq, // Interrupt request level
    output logic txd_out, // Transmit pin output value
    output logic txd_oe_b, // Transmit pin enable, low drives
    input wire logic txd_in, // Transmit pin level seen
    input wire logic rxd_in, // Receive pin level
    output logic tx_pin_owned, // Port owns transmit pin
    output logic rx_pin_owned // Port owns receive pin
);

    spc_state_t s;
    spc_state_t n;

    logic [3:0] frame_len;
    logic tx_tick;
    logic rx_tick;
    logic rx_in;
    logic tc;
    logic single_wire;
    logic [3:0] flags;
    logic [3:0] flag_en;
    spc_ctrl_two_t wr_c2;

    assign wr_c2 = spc_ctrl_two_t'(wdata);
    assign frame_len = s.c1.mode9 ? FRAME_LEN_9 : FRAME_LEN_8;
    assign tx_tick = (s.tx_cnt == 8'h00);
    assign rx_tick = (s.rx_cnt == 8'h00);
    assign single_wire = s.c1.loop_select & s.c1.rx_source_sel;
    // Internal loopback taps the transmit line register directly, no pin involved
    assign rx_in = s.c1.loop_select ? (s.c1.rx_source_sel ? s.txp_s : s.tx_line)
                                    : s.rxd_s;
    assign tc = s.tx_empty & (s.tx_st == TX_IDLE) & ~s.brk_pend & ~s.idle_pend;
    assign flags = {s.tx_empty, tc, s.rx_full, s.idle_flag};
    assign flag_en = {s.c2.tx_empty_irq_en, s.c2.tx_done_irq_en,
                      s.c2.rx_full_irq_en, s.c2.line_quiet_irq_en};

    always_comb begin
        logic [3:0] ev;
        logic [3:0] clr;
        ev = 4'h0;
        clr = 4'h0;
        n = s;
        n.rdata = 8'h00;
        n.rxd_m = rxd_in;
        n.rxd_s = s.rxd_m;
        n.txp_m = txd_in;
        n.txp_s = s.txp_m;

        // Transmit engine
        case (s.tx_st)
            TX_IDLE: begin
                n.tx_line = 1'b1;
                n.tx_cnt = s.baud;
                if (s.tx_own && s.brk_pend) begin
                    n.tx_st = TX_SHIFT;
                    n.tx_kind = K_BREAK;
                    n.brk_pend = 1'b0;
                    n.tx_sh = 14'h0000;
                    n.tx_line = 1'b0;
                    n.tx_left = (s.c1.long_break_sel ? frame_len + LONG_BREAK_EXTRA
                                                     : frame_len) - 4'h1;
                end else if (s.tx_own && s.idle_pend) begin
                    n.tx_st = TX_SHIFT;
                    n.tx_kind = K_IDLE;
                    n.idle_pend = 1'b0;
                    n.tx_sh = 14'h3fff;
                    n.tx_left = frame_len - 4'h1;
                end else if (s.tx_own && !s.tx_empty) begin
                    n.tx_st = TX_SHIFT;
                    n.tx_kind = K_DATA;
                    n.tx_empty = 1'b1;
                    n.tx_sh = s.c1.mode9 ? {4'hf, 1'b1, s.tx_buf}
                                         : {5'h1f, 1'b1, s.tx_buf[7:0]};
                    n.tx_line = 1'b0;
                    n.tx_left = frame_len - 4'h1;
                end
            end
            TX_SHIFT: begin
                if (tx_tick) begin
                    n.tx_cnt = s.baud;
                    if (s.tx_left == 4'h0) begin
                        n.tx_st = TX_IDLE;
                        n.tx_line = 1'b1;
                        if (s.tx_kind == K_BREAK) begin
                            ev[EVT_BRK] = 1'b1;
                            // Request still high: another break follows
                            if (s.c2.break_send) begin
                                n.brk_pend = 1'b1;
                            end
                        end
                        if (s.tx_kind == K_IDLE) begin
                            ev[EVT_IDLE] = 1'b1;
                        end
                    end else begin
                        n.tx_line = s.tx_sh[0];
                        n.tx_sh = {1'b1, s.tx_sh[13:1]};
                        n.tx_left = s.tx_left - 4'h1;
                    end
                end else begin
                    n.tx_cnt = s.tx_cnt - 8'h01;
                end
            end
            default: begin
                n.tx_st = TX_IDLE;
            end
        endcase

        // Register writes; placed after the engine so new data is never lost
        if (wr_en) begin
            case (addr)
                OFS_CTRL_ONE: begin
                    n.c1 = spc_ctrl_one_t'({wdata[7:1], 1'b0});
                end
                OFS_CTRL_TWO: begin
                    n.c2 = wr_c2;
                    if (wr_c2.tx_on && !s.c2.tx_on) begin
                        n.idle_pend = 1'b1;
                    end
                    // A break needs the transmitter, or it would sit unowned
                    if (wr_c2.break_send && !s.c2.break_send && wr_c2.tx_on) begin
                        n.brk_pend = 1'b1;
                    end
                end
                OFS_DATA: begin
                    n.tx_buf = {s.c1.tx_bit8, wdata};
                    n.tx_empty = 1'b0;
                end
                OFS_BAUD: begin
                    n.baud = wdata;
                end
                OFS_EVT_CLR: begin
                    clr = wdata[3:0];
                end
                OFS_EVT_EN: begin
                    n.evt_en = wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        if (rd_en) begin
            case (addr)
                OFS_CTRL_ONE: n.rdata = s.c1;
                OFS_CTRL_TWO: n.rdata = s.c2;
                OFS_STATUS: n.rdata = {flags, s.overrun, s.rx_data[8],
                                       (s.rx_st != RX_IDLE), 1'b0};
                OFS_DATA: begin
                    n.rdata = s.rx_data[7:0];
                    n.rx_full = 1'b0;
                    n.idle_flag = 1'b0;
                    n.overrun = 1'b0;
                end
                OFS_BAUD: n.rdata = s.baud;
                OFS_EVT_STAT: n.rdata = {4'h0, s.evt_st};
                OFS_EVT_EN: n.rdata = {4'h0, s.evt_en};
                default: n.rdata = 8'h00;
            endcase
        end

        // Receive engine; runs after reads so a new flag beats a clear
        if (!s.c2.rx_on) begin
            n.rx_st = RX_IDLE;
            n.rx_cnt = s.baud;
            n.quiet = 4'h0;
        end else begin
            case (s.rx_st)
                RX_IDLE: begin
                    if (!rx_in) begin
                        n.rx_st = RX_START;
                        n.rx_cnt = {1'b0, s.baud[7:1]};
                        n.quiet = 4'h0;
                    end else if (rx_tick) begin
                        n.rx_cnt = s.baud;
                        if (s.quiet != frame_len) begin
                            n.quiet = s.quiet + 4'h1;
                        end
                        // One full character time of high line
                        if (s.quiet + 4'h1 == frame_len) begin
                            if (s.c2.rx_standby && !s.c1.wake_method) begin
                                n.c2.rx_standby = 1'b0;
                                ev[EVT_WAKE] = 1'b1;
                            end else if (s.armed && !s.c2.rx_standby) begin
                                n.idle_flag = 1'b1;
                                n.armed = 1'b0;
                            end
                        end
                    end else begin
                        n.rx_cnt = s.rx_cnt - 8'h01;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        n.rx_cnt = s.baud;
                        n.rx_left = s.c1.mode9 ? DATA_LAST_9 : DATA_LAST_8;
                        n.rx_st = rx_in ? RX_IDLE : RX_DATA;
                    end else begin
                        n.rx_cnt = s.rx_cnt - 8'h01;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        n.rx_cnt = s.baud;
                        n.rx_sh = {rx_in, s.rx_sh[8:1]};
                        n.rx_left = s.rx_left - 4'h1;
                        if (s.rx_left == 4'h0) begin
                            n.rx_st = RX_STOP;
                        end
                    end else begin
                        n.rx_cnt = s.rx_cnt - 8'h01;
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        n.rx_cnt = s.baud;
                        n.rx_st = RX_IDLE;
                        ev[EVT_FERR] = ~rx_in;
                        // Top data bit lands in bit 8 in both formats
                        if (s.c2.rx_standby && s.c1.wake_method && s.rx_sh[8]) begin
                            n.c2.rx_standby = 1'b0;
                            ev[EVT_WAKE] = 1'b1;
                        end
                        if (!s.c2.rx_standby ||
                            (s.c1.wake_method && s.rx_sh[8])) begin
                            if (n.rx_full) begin
                                n.overrun = 1'b1;
                            end else begin
                                n.rx_data = s.c1.mode9 ? s.rx_sh
                                                       : {1'b0, s.rx_sh[8:1]};
                                n.rx_full = 1'b1;
                                n.armed = 1'b1;
                            end
                        end
                    end else begin
                        n.rx_cnt = s.rx_cnt - 8'h01;
                    end
                end
                default: begin
                    n.rx_st = RX_IDLE;
                end
            endcase
        end

        n.evt_st = (s.evt_st & ~clr) | ev;
        // Hold the pin until every queued character has left
        n.tx_own = n.c2.tx_on | (s.tx_own & ((n.tx_st == TX_SHIFT) | n.brk_pend |
                                 n.idle_pend | ~n.tx_empty));
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign irq = (|(flags & flag_en)) | (|(s.evt_st & s.evt_en));
    assign txd_out = s.tx_line;
    // Single wire with direction low turns the line round for receive
    assign txd_oe_b = ~(s.tx_own & ~(single_wire & ~s.c1.single_wire_dir));
    assign tx_pin_owned = s.tx_own;
    assign rx_pin_owned = s.c2.rx_on & ~s.c1.loop_select;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    chk_tx_empty_irq: assert property (s.c2.tx_empty_irq_en && s.tx_empty |-> irq)
        else $error("tx empty enabled but no irq");
    chk_tc_irq: assert property (s.c2.tx_done_irq_en && tc |-> irq)
        else $error("tx complete enabled but no irq");
    chk_rx_full_irq: assert property (s.c2.rx_full_irq_en && s.rx_full |-> irq)
        else $error("rx full enabled but no irq");
    chk_quiet_irq: assert property (s.c2.line_quiet_irq_en && s.idle_flag |-> irq)
        else $error("idle enabled but no irq");
    chk_irq_cause: assert property (irq |-> (|(flags & flag_en)) || (|(s.evt_st & s.evt_en)))
        else $error("irq without enabled cause");
    chk_ctrl_write: assert property (wr_en && addr == OFS_CTRL_TWO
        |=> s.c2.tx_on == $past(wdata[3]) && s.c2.rx_on == $past(wdata[2]))
        else $error("control two write not taken");
    chk_tx_drive: assert property (s.c2.tx_on && !single_wire |-> !txd_oe_b)
        else $error("transmit pin not driven");
    chk_wire_turn: assert property (s.tx_own && single_wire && !s.c1.single_wire_dir
        |-> txd_oe_b)
        else $error("single wire receive still drives");
    chk_queue_idle: assert property (wr_en && addr == OFS_CTRL_TWO && wr_c2.tx_on
        && !s.c2.tx_on |=> s.idle_pend || s.tx_kind == K_IDLE)
        else $error("idle not queued");
    chk_pin_hold: assert property (s.tx_st == TX_SHIFT || s.brk_pend |-> tx_pin_owned)
        else $error("pin released while busy");
    chk_rx_pin: assert property (s.c1.loop_select || !s.c2.rx_on |-> !rx_pin_owned)
        else $error("rx pin kept");
    chk_break_queue: assert property (wr_en && addr == OFS_CTRL_TWO && wr_c2.break_send
        && !s.c2.break_send && wr_c2.tx_on |=> s.brk_pend || s.tx_kind == K_BREAK)
        else $error("break not queued");
    chk_break_low: assert property (s.tx_st == TX_SHIFT && s.tx_kind == K_BREAK
        |-> !txd_out)
        else $error("break bit not low");
    chk_wake_mark: assert property (s.c2.rx_on && s.rx_st == RX_STOP && rx_tick
        && s.c2.rx_standby && s.c1.wake_method && s.rx_sh[8] |=> !s.c2.rx_standby)
        else $error("address mark did not wake");

    cov_break_sent: cover property (s.tx_kind == K_BREAK && $rose(s.evt_st[EVT_BRK]));
    cov_idle_sent: cover property ($rose(s.evt_st[EVT_IDLE]));
    cov_wakeup: cover property ($fell(s.c2.rx_standby));
    cov_rx_irq: cover property ($rose(s.rx_full) && s.c2.rx_full_irq_en);

endmodule // spc_serial_port

// file: core/spc_pkg.sv
package spc_pkg;

    localparam logic [2:0] OFS_CTRL_ONE = 3'h0;
    localparam logic [2:0] OFS_CTRL_TWO = 3'h1;
    localparam logic [2:0] OFS_STATUS = 3'h2;
    localparam logic [2:0] OFS_DATA = 3'h3;
    localparam logic [2:0] OFS_BAUD = 3'h4;
    localparam logic [2:0] OFS_EVT_STAT = 3'h5;
    localparam logic [2:0] OFS_EVT_CLR = 3'h6;
    localparam logic [2:0] OFS_EVT_EN = 3'h7;

    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h07;

    localparam logic [3:0] FRAME_LEN_8 = 4'ha;
    localparam logic [3:0] FRAME_LEN_9 = 4'hb;
    localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
    localparam logic [3:0] DATA_LAST_8 = 4'h7;
    localparam logic [3:0] DATA_LAST_9 = 4'h8;

    localparam int EVT_BRK = 0;
    localparam int EVT_IDLE = 1;
    localparam int EVT_WAKE = 2;
    localparam int EVT_FERR = 3;

    typedef struct packed {
        logic loop_select;
        logic tx_bit8;
        logic rx_source_sel;
        logic mode9;
        logic wake_method;
        logic long_break_sel;
        logic single_wire_dir;
        logic rsvd;
    } spc_ctrl_one_t;

    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic line_quiet_irq_en;
        logic tx_on;
        logic rx_on;
        logic rx_standby;
        logic break_send;
    } spc_ctrl_two_t;

    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} spc_tx_state_t;
    typedef enum logic [1:0] {K_DATA = 2'b00, K_IDLE = 2'b01, K_BREAK = 2'b10} spc_kind_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
    } spc_rx_state_t;

    typedef struct packed {
        spc_ctrl_one_t c1;
        spc_ctrl_two_t c2;
        logic [7:0] baud;
        logic [3:0] evt_st;
        logic [3:0] evt_en;
        logic [7:0] rdata;
        spc_tx_state_t tx_st;
        spc_kind_t tx_kind;
        logic [8:0] tx_buf;
        logic tx_empty;
        logic [13:0] tx_sh;
        logic [3:0] tx_left;
        logic [7:0] tx_cnt;
        logic brk_pend;
        logic idle_pend;
        logic tx_line;
        logic tx_own;
        logic rxd_m;
        logic rxd_s;
        logic txp_m;
        logic txp_s;
        spc_rx_state_t rx_st;
        logic [7:0] rx_cnt;
        logic [8:0] rx_sh;
        logic [3:0] rx_left;
        logic [8:0] rx_data;
        logic rx_full;
        logic idle_flag;
        logic overrun;
        logic armed;
        logic [3:0] quiet;
    } spc_state_t;

    localparam spc_state_t STATE_RST = '{
        c1: spc_ctrl_one_t'(CTRL_ONE_RST), c2: spc_ctrl_two_t'(CTRL_TWO_RST),
        baud: BAUD_RST, tx_st: TX_IDLE, tx_kind: K_DATA, rx_st: RX_IDLE,
        tx_empty: 1'b1, tx_line: 1'b1, rxd_m: 1'b1, rxd_s: 1'b1,
        txp_m: 1'b1, txp_s: 1'b1, default: '0};

endpackage

// file: tb/spc_remote.sv
`timescale 1ns/100ps
module spc_remote #(
    parameter int BIT_CLKS = 8
) (
    input wire logic sys_clk, // System clock, paces bit times
    input wire logic line_in, // Transmit line level from the port
    output logic line_out // Receive line into the port
);
    initial line_out = 1'b1;

    // Start, data LSB first, stop; line rests high between frames
    task automatic send(input logic [8:0] d, input int nb);
        @(posedge sys_clk);
        line_out <= 1'b0;
        repeat (BIT_CLKS) @(posedge sys_clk);
        for (int i = 0; i < nb; i++) begin
            line_out <= d[i];
            repeat (BIT_CLKS) @(posedge sys_clk);
        end
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge sys_clk);
    endtask

    // Samples at mid bit; bounded wait so a dead line cannot hang
    task automatic recv(output logic [8:0] d, input int nb);
        int w;
        d = '0;
        w = 0;
        while (line_in !== 1'b0 && w < 3000) begin
            @(posedge sys_clk);
            w++;
        end
        repeat (BIT_CLKS / 2) @(posedge sys_clk);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT_CLKS) @(posedge sys_clk);
            d[i] = line_in;
        end
    endtask

    task automatic low_run(output int n);
        int w;
        n = 0;
        w = 0;
        while (line_in !== 1'b0 && w < 3000) begin
            @(posedge sys_clk);
            w++;
        end
        while (line_in === 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
endmodule // spc_remote

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import spc_pkg::*;
    localparam int BIT_CLKS = 8;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic irq, txd_out, txd_oe_b, rxd_in, tx_pin_owned, rx_pin_owned;
    wire tx_line = txd_oe_b ? 1'b1 : txd_out; // Pull-up holds a released pin high
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 86077;
    int n;
    logic [7:0] v, s, c;
    logic [8:0] d, got;

    spc_serial_port spc_serial_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .txd_out(txd_out), .txd_oe_b(txd_oe_b), .txd_in(tx_line), .rxd_in(rxd_in),
        .tx_pin_owned(tx_pin_owned), .rx_pin_owned(rx_pin_owned));
    spc_remote #(.BIT_CLKS(BIT_CLKS)) spc_remote_inst (.sys_clk(sys_clk), .line_in(tx_line),
        .line_out(rxd_in));

    always #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count = err_count + 1;
            print_verdict();
        end
    end

    task print_verdict;
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task wr(input logic [2:0] a, input logic [7:0] dv);
        @(posedge sys_clk);
        addr <= a;
        wdata <= dv;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task rd(input logic [2:0] a, output logic [7:0] dv);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 dv = rdata;
    endtask

    task chk_val(input logic [8:0] g, input logic [8:0] e, input string what);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask

    // Either one break or two run together is legal
    task chk_run(input int g, input int e);
        comparisons++;
        if (g != e && g != 2 * e) begin
            err_count++;
            $display("ERROR %0t break length %0d exp %0d", $time, g, e);
        end
    endtask

    function automatic logic exp_irq(input logic [7:0] ct, input logic [7:0] st);
        return |(ct[7:4] & st[7:4]);
    endfunction

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_CTRL_TWO, v);
        chk_val(v, 9'h000, "ctrl reset");
        chk_val(tx_pin_owned, 1'b0, "tx own reset");
        for (int i = 0; i < 10; i++) begin
            c = (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : 8'($random(seed)) & 8'hf4;
            wr(OFS_CTRL_TWO, c);
            chk_val(irq, exp_irq(c, 8'hc0), "irq enables");
            chk_val(rx_pin_owned, c[2], "rx own");
            rd(OFS_CTRL_TWO, v);
            chk_val(v, c, "ctrl readback");
        end
        wr(OFS_CTRL_ONE, 8'h80);
        chk_val(rx_pin_owned, 1'b0, "rx own loop");
        wr(OFS_CTRL_ONE, 8'h00);
        wr(OFS_CTRL_TWO, 8'h24);
        d = {1'b0, 8'($random(seed))};
        spc_remote_inst.send(d, 8);
        repeat (BIT_CLKS) @(posedge sys_clk);
        rd(OFS_STATUS, s);
        chk_val(s[5], 1'b1, "rx full");
        chk_val(irq, exp_irq(8'h24, s), "rx irq");
        wr(OFS_CTRL_TWO, 8'h14);
        repeat (12 * BIT_CLKS) @(posedge sys_clk);
        rd(OFS_STATUS, s);
        chk_val(s[4], 1'b1, "idle flag");
        chk_val(irq, 1'b1, "idle irq");
        rd(OFS_DATA, v);
        chk_val(v, d, "rx data");
        chk_val(irq, 1'b0, "irq after read");
        wr(OFS_CTRL_TWO, 8'h0c);
        chk_val({tx_pin_owned, txd_oe_b}, 2'b10, "tx own");
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL_ONE, m ? 8'h50 : 8'h00);
            d = {m[0], 8'($random(seed))};
            wr(OFS_DATA, d[7:0]);
            spc_remote_inst.recv(got, 8 + m);
            chk_val(got, d, "tx frame");
        end
        wr(OFS_EVT_EN, 8'h01);
        for (int lb = 0; lb < 2; lb++) begin
            wr(OFS_CTRL_ONE, lb ? 8'h04 : 8'h00);
            wr(OFS_CTRL_TWO, 8'h0d);
            wr(OFS_CTRL_TWO, 8'h0c);
            spc_remote_inst.low_run(n);
            chk_run(n, (10 + 3 * lb) * BIT_CLKS);
        end
        repeat (2 * BIT_CLKS) @(posedge sys_clk);
        chk_val(irq, 1'b1, "event irq");
        wr(OFS_EVT_EN, 8'h00);
        chk_val(irq, 1'b0, "event masked");
        wr(OFS_EVT_EN, 8'h01);
        chk_val(irq, 1'b1, "event unmasked");
        wr(OFS_EVT_CLR, 8'h01);
        chk_val(irq, 1'b0, "event cleared");
        rd(OFS_EVT_CLR, v);
        chk_val(v, 9'h000, "clear reads zero");
        d = {1'b0, 8'($random(seed))};
        wr(OFS_DATA, d[7:0]);
        wr(OFS_CTRL_TWO, 8'h00);
        chk_val(tx_pin_owned, 1'b1, "own held");
        spc_remote_inst.recv(got, 8);
        chk_val(got, d, "last frame");
        repeat (2 * BIT_CLKS) @(posedge sys_clk);
        chk_val({tx_pin_owned, txd_oe_b}, 2'b01, "own released");
        wr(OFS_CTRL_ONE, 8'h08);
        wr(OFS_CTRL_TWO, 8'h06);
        spc_remote_inst.send(9'h012, 8);
        repeat (BIT_CLKS) @(posedge sys_clk);
        rd(OFS_STATUS, s);
        chk_val(s[5], 1'b0, "standby discards");
        spc_remote_inst.send(9'h085, 8);
        repeat (BIT_CLKS) @(posedge sys_clk);
        rd(OFS_CTRL_TWO, v);
        chk_val(v, 9'h004, "standby cleared");
        rd(OFS_DATA, v);
        chk_val(v, 9'h085, "wake char");
        wr(OFS_CTRL_ONE, 8'h80);
        wr(OFS_CTRL_TWO, 8'h0c);
        d = {1'b0, 8'($random(seed))};
        wr(OFS_DATA, d[7:0]);
        repeat (24 * BIT_CLKS) @(posedge sys_clk);
        rd(OFS_DATA, v);
        chk_val(v, d, "loopback data");
        wr(OFS_CTRL_ONE, 8'ha0);
        chk_val(txd_oe_b, 1'b1, "single wire receive");
        wr(OFS_CTRL_ONE, 8'ha2);
        chk_val(txd_oe_b, 1'b0, "single wire drive");
        print_verdict();
    end
endmodule // tb
